// [include/adcctl_defines.svh]
`ifndef ADCCTL_DEFINES_SVH
`define ADCCTL_DEFINES_SVH
`define ADCCTL_STRAP_LOW 2'h0
`define ADCCTL_STRAP_FLOAT 2'h1
`define ADCCTL_STRAP_HIGH 2'h2
`define ADCCTL_FULL_SCALE 12'hfff
`define ADCCTL_LOCK_TIME_NS 52000
`define ADCCTL_CLK_PERIOD_NS 40
`define ADCCTL_LOCK_CYCLES (`ADCCTL_LOCK_TIME_NS / `ADCCTL_CLK_PERIOD_NS)
`define ADCCTL_LATENCY_HALF 17
`define ADCCTL_CAL_CYCLES 64
`define ADCCTL_SLOW_MIN 40
`define ADCCTL_SLOW_MAX 100
`define ADCCTL_FAST_MIN 80
`endif

// [include/adcctl_pkg.sv]
package adcctl_pkg;
   typedef enum logic [1:0] {ADCCTL_DIV1, ADCCTL_DIV2, ADCCTL_DIV4} adcctl_div_t;
   typedef enum logic [1:0] {ADCCTL_CMOS, ADCCTL_LVDS3, ADCCTL_LVDS2} adcctl_omode_t;
   typedef enum logic [1:0] {ADCCTL_CAL, ADCCTL_LOCK, ADCCTL_RUN} adcctl_state_t;
endpackage : adcctl_pkg

// [rtl/adcctl_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // write side
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // read side
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_r;
   logic [AW:0] rdPtr_r;
   wire doWrite = inValid && inReady;
   wire doRead = outValid && outReady;
   wire isEmpty = (wrPtr_r == rdPtr_r);
   wire isFull = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) && (wrPtr_r[AW] != rdPtr_r[AW]);
   assign inReady = !isFull;
   assign outValid = !isEmpty;
   assign outData = mem[rdPtr_r[AW-1:0]];
   always_ff @(posedge clk_sys) begin
      if (doWrite) mem[wrPtr_r[AW-1:0]] <= inData;
   end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (doWrite) wrPtr_r <= wrPtr_r + 1'b1;
         if (doRead) rdPtr_r <= rdPtr_r + 1'b1;
      end
   end
   a_fifo_noover: assert property (@(posedge clk_sys) disable iff (reset)
      isFull |-> !inReady) else $error("fifo accepts while full");
endmodule : adcctl_fifo
`default_nettype wire

// [rtl/adcctl_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_defines.svh"
module adcctl_top import adcctl_pkg::*; #(
   parameter int LOCK_CYCLES = `ADCCTL_LOCK_CYCLES,
   parameter int CAL_CYCLES = `ADCCTL_CAL_CYCLES,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // straps and configuration overrides
   input wire logic [1:0] clock_divide_strap,
   input wire logic [1:0] output_type_strap,
   input wire logic divOverrideEn,
   input wire logic [1:0] divOverride,
   input wire logic modeOverrideEn,
   input wire logic [1:0] modeOverride,
   input wire logic ddrSelect,
   input wire logic smallPackage,
   input wire logic dllSlowRange,
   input wire logic [9:0] sampleRateMsps,
   input wire logic powerDown,
   input wire logic calibration_reset_pin_n,
   // converter core
   input wire logic [12:0] coreCode,
   input wire logic coreValid,
   output logic coreReady,
   // output pins
   output logic [11:0] dataOut,
   output logic [11:0] dataOutEn,
   output logic overRange,
   output logic overRangeEn,
   output logic sample_output_clock,
   output logic sampleClockEn,
   // status
   output logic dllLocked,
   output logic dllRangeOk,
   output logic lvdsMode,
   output logic lvdsLowDrive,
   output logic ddrActive,
   output logic [1:0] divRatioCode
);
   initial begin
      if (LOCK_CYCLES < 1 || CAL_CYCLES < 1) $error("counts must be at least one");
   end
   adcctl_div_t divSel;
   adcctl_omode_t modeSel;
   adcctl_state_t state_r, state_nxt;
   function automatic adcctl_div_t divFromStrap(input logic [1:0] s);
      if (s == `ADCCTL_STRAP_LOW) return ADCCTL_DIV2;
      else if (s == `ADCCTL_STRAP_HIGH) return ADCCTL_DIV4;
      else return ADCCTL_DIV1;
   endfunction : divFromStrap
   function automatic adcctl_omode_t modeFromStrap(input logic [1:0] s);
      if (s == `ADCCTL_STRAP_LOW) return ADCCTL_CMOS;
      else if (s == `ADCCTL_STRAP_HIGH) return ADCCTL_LVDS2;
      else return ADCCTL_LVDS3;
   endfunction : modeFromStrap
   // the configuration port wins over the straps
   assign divSel = divOverrideEn ? divFromStrap(divOverride) : divFromStrap(clock_divide_strap);
   assign modeSel = modeOverrideEn ? modeFromStrap(modeOverride)
                                   : modeFromStrap(output_type_strap);
   assign divRatioCode = divSel;
   assign lvdsMode = (modeSel != ADCCTL_CMOS);
   assign lvdsLowDrive = (modeSel == ADCCTL_LVDS2);
   // small package only has six pairs, so double rate is forced there
   assign ddrActive = ddrSelect || smallPackage;
   assign dllRangeOk = dllSlowRange
      ? (sampleRateMsps >= 10'(`ADCCTL_SLOW_MIN) && sampleRateMsps <= 10'(`ADCCTL_SLOW_MAX))
      : (sampleRateMsps >= 10'(`ADCCTL_FAST_MIN));

   // sample enable from divider; div2 gives half-rate samples for phase slip
   logic [1:0] divCnt_r;
   wire [1:0] divLast = (divSel == ADCCTL_DIV4) ? 2'h3 : (divSel == ADCCTL_DIV2) ? 2'h1 : 2'h0;
   wire sampleTick = (divCnt_r >= divLast);
   always_ff @(posedge clk_sys) begin
      if (reset || sampleTick) divCnt_r <= 2'h0;
      else divCnt_r <= divCnt_r + 2'h1;
   end

   // relock after any change of divider or range, except one on the last cycle of the lock count
   logic [1:0] divPrev_r;
   logic slowPrev_r;
   logic [31:0] lockCnt_r;
   logic [31:0] calCnt_r;
   wire rateChange = (divPrev_r != divSel) || (slowPrev_r != dllSlowRange);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         divPrev_r <= 2'h0;
         slowPrev_r <= 1'b0;
      end else begin
         divPrev_r <= divSel;
         slowPrev_r <= dllSlowRange;
      end
   end
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ADCCTL_CAL: if (calibration_reset_pin_n && calCnt_r >= 32'(CAL_CYCLES - 1))
            state_nxt = ADCCTL_LOCK;
         ADCCTL_LOCK: if (lockCnt_r >= 32'(LOCK_CYCLES - 1)) state_nxt = ADCCTL_RUN;
         ADCCTL_RUN: if (rateChange) state_nxt = ADCCTL_LOCK;
         default: state_nxt = ADCCTL_CAL;
      endcase
      if (!calibration_reset_pin_n) state_nxt = ADCCTL_CAL;
   end
   always_ff @(posedge clk_sys) begin
      if (reset) state_r <= ADCCTL_CAL;
      else state_r <= state_nxt;
   end
   always_ff @(posedge clk_sys) begin
      if (reset || !calibration_reset_pin_n || state_r != ADCCTL_CAL) calCnt_r <= '0;
      else calCnt_r <= calCnt_r + 32'h1;
   end
   always_ff @(posedge clk_sys) begin
      if (reset || state_r != ADCCTL_LOCK || rateChange) lockCnt_r <= '0;
      else lockCnt_r <= lockCnt_r + 32'h1;
   end
   assign dllLocked = (state_r == ADCCTL_RUN);

   // latency line: 17 stages, each advanced once per full output clock period on wordTick
   logic [12:0] fifoData;
   logic fifoValid;
   logic fifoTake;
   adcctl_fifo #(.WIDTH(13), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .inData(coreCode),
      .inValid(coreValid),
      .inReady(coreReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(fifoTake)
   );
   localparam int LAT = `ADCCTL_LATENCY_HALF;
   logic [12:0] pipe_r [LAT];
   logic phase_r;
   wire running = dllLocked && !powerDown;
   // one word per sample period, after the full phase pair
   wire wordTick = running && sampleTick && phase_r;
   assign fifoTake = wordTick && fifoValid;
   // saturate: a core overflow clamps to full scale instead of wrapping
   wire [11:0] clamped = fifoData[12] ? `ADCCTL_FULL_SCALE : fifoData[11:0];
   wire [12:0] pipeIn = fifoValid ? {fifoData[12], clamped} : 13'h0;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < LAT; i++) pipe_r[i] <= 13'h0;
      end else if (wordTick) begin
         pipe_r[0] <= pipeIn;
         for (int i = 1; i < LAT; i++) pipe_r[i] <= pipe_r[i-1];
      end
   end
   // output clock half-phase toggles with each sample enable while running
   always_ff @(posedge clk_sys) begin
      if (reset || !calibration_reset_pin_n) phase_r <= 1'b0;
      else if (running && sampleTick) phase_r <= !phase_r;
   end
   wire [12:0] word = pipe_r[LAT-1];
   wire wordOr = word[12] || (word[11:0] == `ADCCTL_FULL_SCALE);

   // ddr: low phase msb and odd bits, high phase lsb and even bits, on even lines
   // lines are loaded on the tick that flips the phase, so they follow the next phase
   logic [11:0] ddrLines;
   always_comb begin
      ddrLines = 12'h0;
      for (int k = 0; k < 6; k++) begin
         ddrLines[2*k] = phase_r ? word[2*k+1] : word[2*k];
      end
   end
   logic [11:0] dataOut_r;
   logic overRange_r;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dataOut_r <= 12'h0;
         overRange_r <= 1'b1;
      end else if (!calibration_reset_pin_n || state_r == ADCCTL_CAL) begin
         overRange_r <= 1'b1;
      end else if (running && sampleTick) begin
         dataOut_r <= ddrActive ? ddrLines : word[11:0];
         if (!phase_r) overRange_r <= wordOr;
      end
   end
   assign dataOut = dataOut_r;
   assign overRange = overRange_r;
   assign sample_output_clock = phase_r;
   // power-down releases every output pin
   wire drive = !powerDown;
   assign dataOutEn = (drive && ddrActive) ? 12'h555 : (drive ? 12'hfff : 12'h0);
   assign overRangeEn = drive;
   assign sampleClockEn = drive;

   a_or_cal: assert property (@(posedge clk_sys) disable iff (reset)
      !calibration_reset_pin_n |=> overRange) else $error("flag low during calibration");
   a_clk_held: assert property (@(posedge clk_sys) disable iff (reset)
      !calibration_reset_pin_n |=> !sample_output_clock) else $error("clock toggles in reset");
   a_no_wrap: assert property (@(posedge clk_sys) disable iff (reset)
      fifoData[12] |-> clamped == 12'hfff) else $error("code wrapped");
   a_div_over: assert property (@(posedge clk_sys) disable iff (reset)
      divOverrideEn |-> divSel == divFromStrap(divOverride)) else $error("override lost");
   a_mode_over: assert property (@(posedge clk_sys) disable iff (reset)
      modeOverrideEn |-> modeSel == modeFromStrap(modeOverride)) else $error("mode lost");
   a_small_ddr: assert property (@(posedge clk_sys) disable iff (reset)
      smallPackage |-> ddrActive) else $error("sdr on small package");
   a_hiz_sleep: assert property (@(posedge clk_sys) disable iff (reset)
      powerDown |-> !overRangeEn && !sampleClockEn && dataOutEn == 12'h0)
      else $error("driving in power-down");
   a_relock: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == ADCCTL_RUN && rateChange && calibration_reset_pin_n) |=> !dllLocked)
      else $error("no relock");
   a_div_ratio: assert property (@(posedge clk_sys) disable iff (reset)
      (divSel == ADCCTL_DIV2 && sampleTick && !rateChange) |=> !sampleTick)
      else $error("divide by two broken");
endmodule : adcctl_top
`default_nettype wire

// [verification/adcctl_capture_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_capture_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // device outputs
   input wire logic [11:0] dataOut,
   input wire logic overRange,
   input wire logic sample_output_clock,
   input wire logic sampleClockEn,
   input wire logic ddrActive,
   // captured sample
   output logic [11:0] capWord,
   output logic capOr,
   output int capCount
);
   logic [11:0] lowHalf;
   logic [11:0] merged;
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         merged[2*k+1] = lowHalf[2*k];
         merged[2*k] = dataOut[2*k];
      end
   end
   // receiver sits next to the converter, so low drive is acceptable here
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         capCount <= 0;
         capWord <= 12'h000;
         capOr <= 1'h0;
         lowHalf <= 12'h000;
      end else if (sampleClockEn && !sample_output_clock) begin
         lowHalf <= dataOut;
         capOr <= overRange;
      end else if (sampleClockEn) begin
         capWord <= ddrActive ? merged : dataOut;
         capCount <= capCount + 1;
      end
   end
endmodule : adcctl_capture_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adcctl_pkg::*;
   logic clk_sys = 1'h0, reset = 1'h1, divOverrideEn = 1'h0, modeOverrideEn = 1'h0;
   logic [1:0] clock_divide_strap = 2'h1, output_type_strap = 2'h1;
   logic [1:0] divOverride = 2'h0, modeOverride = 2'h0;
   logic ddrSelect = 1'h0, smallPackage = 1'h0, dllSlowRange = 1'h0, powerDown = 1'h0;
   logic calibration_reset_pin_n = 1'h0, coreValid = 1'h0;
   logic [9:0] sampleRateMsps = 10'h0fa;
   logic [12:0] coreCode = 13'h0000;
   logic coreReady, overRange, overRangeEn, sample_output_clock, sampleClockEn;
   logic dllLocked, dllRangeOk, lvdsMode, lvdsLowDrive, ddrActive, capOr;
   logic [11:0] dataOut, dataOutEn, capWord;
   logic [1:0] divRatioCode;
   int capCount, n_fail = 0, checks = 0;
   always #20 clk_sys = ~clk_sys;
   adcctl_top #(.LOCK_CYCLES(8), .CAL_CYCLES(4), .FIFO_DEPTH(16)) i_dut (.*);
   adcctl_capture_model i_cap (.clk_sys(clk_sys), .reset(reset), .dataOut(dataOut),
      .overRange(overRange), .sample_output_clock(sample_output_clock),
      .sampleClockEn(sampleClockEn), .ddrActive(ddrActive), .capWord(capWord),
      .capOr(capOr), .capCount(capCount));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic wait_lock();
      int n;
      for (n = 0; n < 400 && dllLocked !== 1'h1; n++) cyc(1);
      check("dllLocked", dllLocked, 1'h1);
      if (n == 400) tally_and_finish();
   endtask : wait_lock
   task automatic push(logic [12:0] v);
      int n;
      coreCode = v;
      coreValid = 1'h1;
      for (n = 0; n < 400 && coreReady !== 1'h1; n++) cyc(1);
      if (n == 400) begin
         check("coreReady", coreReady, 1'h1);
         tally_and_finish();
      end
      cyc(1);
   endtask : push
   task automatic t_cal();
      logic c;
      check("calOverRange", overRange, 1'h1);
      repeat (6) begin
         cyc(1);
         check("calClock", sample_output_clock, 1'h0);
      end
      calibration_reset_pin_n = 1'h1;
      wait_lock();
      cyc(2);
      c = sample_output_clock;
      cyc(1);
      check("clockRuns", sample_output_clock, !c);
      check("firstWords", capCount > 0, 1'h1);
      $display("test cal done");
   endtask : t_cal
   task automatic t_straps();
      logic [1:0] divExp [3] = '{2'h1, 2'h0, 2'h2};
      // divide by two expects the source clock at twice the sample rate
      for (int s = 0; s < 3; s++) begin
         clock_divide_strap = 2'(s);
         output_type_strap = 2'(s);
         cyc(1);
         check("divRatioCode", divRatioCode, divExp[s]);
         check("lvdsMode", lvdsMode, s != 0);
         check("lvdsLowDrive", lvdsLowDrive, s == 2);
         divOverrideEn = 1'h1;
         modeOverrideEn = 1'h1;
         divOverride = 2'((s + 1) % 3);
         modeOverride = 2'((s + 1) % 3);
         cyc(1);
         check("divOverride", divRatioCode, divExp[(s + 1) % 3]);
         check("modeOverride", lvdsMode, s != 2);
         divOverrideEn = 1'h0;
         modeOverrideEn = 1'h0;
      end
      clock_divide_strap = 2'h1;
      output_type_strap = 2'h1;
      wait_lock();
      $display("test straps done");
   endtask : t_straps
   task automatic t_outs();
      logic [10:0] rates [7] = '{11'h028, 11'h064, 11'h027, 11'h065, 11'h050, 11'h04f, 11'h0fa};
      logic [6:0] rateOk = 7'h53;
      for (int r = 0; r < 7; r++) begin
         dllSlowRange = r < 4;
         sampleRateMsps = rates[r][9:0];
         cyc(1);
         check("dllRangeOk", dllRangeOk, rateOk[r]);
      end
      dllSlowRange = 1'h0;
      for (int m = 0; m < 3; m++) begin
         ddrSelect = m == 1;
         smallPackage = m == 2;
         cyc(1);
         check("ddrActive", ddrActive, m != 0);
         check("dataOutEn", dataOutEn, m != 0 ? 12'h555 : 12'hfff);
      end
      powerDown = 1'h1;
      cyc(1);
      check("pdEn", {dataOutEn, overRangeEn, sampleClockEn}, 15'h0000);
      $display("test outputs done");
   endtask : t_outs
   task automatic t_fill();
      int got = 0;
      coreValid = 1'h1;
      coreCode = 13'h05a3;
      repeat (24) begin
         if (coreReady === 1'h1) got++;
         cyc(1);
      end
      check("fifoDepth", got, 16'h0010);
      check("fifoFull", coreReady, 1'h0);
      coreValid = 1'h0;
      powerDown = 1'h0;
      smallPackage = 1'h0;
      ddrSelect = 1'h0;
      wait_lock();
      cyc(60);
      check("drained", coreReady, 1'h1);
      check("drainWord", capWord, 12'h5a3);
      $display("test fill done");
   endtask : t_fill
   task automatic t_stream(logic ddr, logic [12:0] v, logic [11:0] w, logic o);
      ddrSelect = ddr;
      repeat (40) push(v);
      coreValid = 1'h0;
      cyc(50);
      check("capWord", capWord, w);
      check("capOr", capOr, o);
      $display("test stream %h done", v);
   endtask : t_stream
   initial begin
      cyc(20);
      reset = 1'h0;
      t_cal();
      t_straps();
      t_outs();
      t_fill();
      t_stream(1'h1, 13'h05a3, 12'h5a3, 1'h0);
      t_stream(1'h1, 13'h1003, 12'hfff, 1'h1);
      t_stream(1'h0, 13'h0fff, 12'hfff, 1'h1);
      t_stream(1'h0, 13'h07fe, 12'h7fe, 1'h0);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
